// ===== common/lbr_pkg.sv
/*
  Shared constants and carrier types of the per-channel loop-back router.
  Assumes one APB slave per channel with 32-bit data and byte addresses.
*/
package lbr_pkg;

  // timing
  localparam int unsigned LBR_CLK_NS       = 8;
  localparam int unsigned LBR_LINK_HALF_NS = 80;
  // least time, rounded up to whole pclk cycles
  localparam int unsigned LBR_HALF_CYC     = (LBR_LINK_HALF_NS + LBR_CLK_NS - 1) / LBR_CLK_NS;

  // register map (byte addresses)
  localparam logic [7:0] LBR_CTRL_OFS = 8'h00;
  localparam logic [7:0] LBR_STAT_OFS = 8'h04;

  // jitter attenuator depth
  localparam int unsigned LBR_JA_DEPTH_DEF = 32;

  // loop-back modes, gray coded along none-analog-remote-digital-dual
  typedef enum logic [2:0] {
    LBR_NONE    = 3'h0,
    LBR_ANALOG  = 3'h1,
    LBR_REMOTE  = 3'h3,
    LBR_DIGITAL = 3'h2,
    LBR_DUAL    = 3'h6
  } lbr_mode_type;

  // control register, bit 6 down to bit 0
  typedef struct packed {
    logic       auto_en;             // bit 6: loop-up requests may start remote loop-back
    logic       ja_in_rx;            // bit 5: attenuator in receive path (else transmit)
    logic       ja_en;               // bit 4: attenuator enabled
    logic       host_mode;           // bit 3: host bits select the mode, else pins
    logic       lb_host_enable_bit;  // bit 2: host loop-back enable
    logic [1:0] lb_host_sel;         // bits 1:0: host mode pair
  } lbr_ctrl_type;

  localparam logic [6:0] LBR_CTRL_RST = 7'h00;

  // status register, bit 5 down to bit 0
  typedef struct packed {
    logic         ja_primed;  // bit 5
    logic         loop_up;    // bit 4
    logic         auto_rl;    // bit 3
    lbr_mode_type mode;       // bits 2:0
  } lbr_stat_type;

  // one bit of a clocked bipolar stream: strobe marks the bit
  typedef struct packed {
    logic stb;
    logic pos;
    logic neg;
  } lbr_bit_type;

  // inputs from outside the pclk domain
  typedef struct packed {
    logic tx_clk;
    logic tx_pos;
    logic tx_neg;
    logic rx_clk;
    logic rx_pos;
    logic rx_neg;
    logic pin_hi;
    logic pin_lo;
    logic loop_up;
    logic loop_down;
  } lbr_sync_type;

  localparam logic [9:0] LBR_SYNC_RST = 10'h000;

endpackage

// ===== core/lbr_ja_mem.sv
/*
  Small dual-address memory for the jitter attenuator elastic store.
  Assumes one write and one read per cycle at most, both on pclk.
*/
`timescale 1ns/100ps

module lbr_ja_mem #(
  parameter int unsigned WIDTH = 2,
  parameter int unsigned DEPTH = 32,
  parameter int unsigned AW    = $clog2(DEPTH)
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             rd_en,
  input  wire logic [AW-1:0]    rd_addr,
  output      logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem_r [DEPTH];

  initial begin
    if (DEPTH < 4 || (1 << AW) != DEPTH) begin
      $error("lbr_ja_mem: DEPTH must be a power of two, at least 4");
    end
  end

  // storage needs no reset: nothing is read before it was written
  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= mem_r[rd_addr];
    end
  end

endmodule // lbr_ja_mem

// ===== core/lbr_router.sv
/*
  Per-channel loop-back router: steers transmit and receive bit streams between
  the framer, the line and the jitter attenuator; APB control and status.
  Assumes line and framer clocks far slower than pclk (160 ns link period), and
  that the line receive inputs are already sliced digital data.
*/
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/100ps

// How it works
// - With host_mode clear, pins hi/lo select none 00, analog 01, remote 10, digital 11.
// - With host_mode set, a clear enable bit gives none, else the pair 00/01/10/11 gives dual/analog/remote/digital.
// - Analog loop-back feeds the receiver from the transmit line output and ignores the line inputs.
// - Analog loop-back keeps sending transmit data to the line.
// - Analog loop-back keeps the attenuator working in whichever path it is set for.
// - Remote loop-back with the attenuator in receive feeds attenuated receive data to the line on recovered timing.
// - Remote loop-back ignores framer transmit clock and data but keeps the receive outputs running.
// - Remote loop-back with the attenuator in transmit feeds recovered data through the attenuator to the line.
// - Digital loop-back returns framer transmit clock and data through the attenuator to the receive outputs.
// - Digital loop-back ignores line receive data while still sending framer data to the line.
// - Dual loop-back sends recovered line data straight back to the line, bypassing the attenuator.
// - Dual loop-back sends framer transmit data through the attenuator to the receive outputs.
// - Dual loop-back routes identically whatever path the attenuator is set for.
// - A far-end loop-up request never starts remote loop-back while analog loop-back is selected.
module lbr_router
  import lbr_pkg::*;
#(
  parameter int unsigned JA_DEPTH = LBR_JA_DEPTH_DEF,
  parameter int unsigned HALF_CYC = LBR_HALF_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output      logic        pready,
  output      logic [31:0] prdata,
  output      logic        pslverr,
  input  wire logic        lb_pin_select_hi,
  input  wire logic        lb_pin_select_lo,
  input  wire logic        loop_up_req,
  input  wire logic        loop_down_req,
  input  wire logic        sys_tx_clk,
  input  wire logic        sys_tx_pos,
  input  wire logic        sys_tx_neg,
  input  wire logic        rx_rec_clk,
  input  wire logic        rx_line_pos,
  input  wire logic        rx_line_neg,
  output      logic        tx_line_pos,
  output      logic        tx_line_neg,
  output      logic        tx_line_clk,
  output      logic        rx_data_pos_out,
  output      logic        rx_data_neg_out,
  output      logic        rx_clk_out
);

  localparam int unsigned AW = $clog2(JA_DEPTH);
  localparam int unsigned CW = $clog2(HALF_CYC + 1);
  localparam logic [CW-1:0] HALF_LD = CW'(HALF_CYC);
  localparam logic [AW:0]   JA_FILL = (AW+1)'(JA_DEPTH / 2);

  initial begin
    if (JA_DEPTH < 4 || (1 << AW) != JA_DEPTH) begin
      $error("lbr_router: JA_DEPTH must be a power of two, at least 4");
    end
    if (HALF_CYC < 2) begin
      $error("lbr_router: HALF_CYC must be at least 2");
    end
  end

  typedef struct packed {
    lbr_sync_type  s1;
    lbr_sync_type  s2;
    lbr_sync_type  s3;
    lbr_ctrl_type  ctrl;
    logic [31:0]   rdata;
    logic          slverr;
    lbr_mode_type  mode;
    logic          auto_rl;
    logic [AW-1:0] ja_wp;
    logic [AW-1:0] ja_rp;
    logic [AW:0]   ja_fill;
    logic          ja_rd_q;
    lbr_bit_type   line_q;
    lbr_bit_type   rxo_q;
    logic [CW-1:0] line_cnt;
    logic [CW-1:0] rxo_cnt;
  } lbr_state_type;

  lbr_state_type st_r;
  lbr_state_type st_nxt;

  logic          ja_wr;
  logic          ja_rd;
  logic [1:0]    ja_wdata;
  logic [1:0]    ja_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // mode decoding

  function automatic lbr_mode_type pin_mode(input logic hi, input logic lo);
    case ({hi, lo})
      2'b01:   pin_mode = LBR_ANALOG;
      2'b10:   pin_mode = LBR_REMOTE;
      2'b11:   pin_mode = LBR_DIGITAL;
      default: pin_mode = LBR_NONE;
    endcase
  endfunction

  function automatic lbr_mode_type host_mode(input logic en, input logic [1:0] sel);
    if (!en) begin
      host_mode = LBR_NONE;
    end else begin
      case (sel)
        2'b00:   host_mode = LBR_DUAL;
        2'b01:   host_mode = LBR_ANALOG;
        2'b10:   host_mode = LBR_REMOTE;
        default: host_mode = LBR_DIGITAL;
      endcase
    end
  endfunction

  // output stage: data changes on the strobe, clock rises half a bit later
  function automatic logic [CW-1:0] half_cnt(input logic stb, input logic [CW-1:0] cnt);
    if (stb) begin
      half_cnt = HALF_LD;
    end else if (cnt != '0) begin
      half_cnt = cnt - CW'(1);
    end else begin
      half_cnt = '0;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state

  lbr_mode_type sel_mode;
  lbr_bit_type  tx_src;
  lbr_bit_type  rec;
  lbr_bit_type  ja_in;
  lbr_bit_type  ja_out;
  lbr_bit_type  ja_stream;
  lbr_bit_type  line_src;
  lbr_bit_type  rx_src;
  logic         ja_from_rec;
  logic         ja_flush;
  logic         setup;
  logic         wr_acc;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = lbr_sync_type'({sys_tx_clk, sys_tx_pos, sys_tx_neg, rx_rec_clk, rx_line_pos,
                                rx_line_neg, lb_pin_select_hi, lb_pin_select_lo,
                                loop_up_req, loop_down_req});
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;

    // APB
    setup  = psel && !penable;
    wr_acc = psel && penable && pwrite;
    if (setup) begin
      st_nxt.rdata  = 32'h0000_0000;
      st_nxt.slverr = 1'b0;
      if (paddr == LBR_CTRL_OFS) begin
        st_nxt.rdata = {25'h000_0000, st_r.ctrl};
      end else if (paddr == LBR_STAT_OFS) begin
        st_nxt.rdata = {26'h000_0000, lbr_stat_type'({st_r.ja_fill >= JA_FILL, st_r.s2.loop_up,
                                                     st_r.auto_rl, st_r.mode})};
      end else begin
        st_nxt.slverr = 1'b1;
      end
    end
    if (wr_acc && paddr == LBR_CTRL_OFS) begin
      st_nxt.ctrl = lbr_ctrl_type'(pwdata[6:0]);
    end

    // mode selection
    sel_mode = st_r.ctrl.host_mode ?
               host_mode(st_r.ctrl.lb_host_enable_bit, st_r.ctrl.lb_host_sel) :
               pin_mode(st_r.s2.pin_hi, st_r.s2.pin_lo);
    // a far-end request acts only while the local choice is none, so never in analog
    if (!st_r.ctrl.auto_en || sel_mode != LBR_NONE || st_r.s2.loop_down) begin
      st_nxt.auto_rl = 1'b0;
    end else if (st_r.s2.loop_up) begin
      st_nxt.auto_rl = 1'b1;
    end
    st_nxt.mode = (st_r.auto_rl && sel_mode == LBR_NONE) ? LBR_REMOTE : sel_mode;

    // source streams, sampled on rising edges of the synchronised clocks
    tx_src.stb = st_r.s2.tx_clk && !st_r.s3.tx_clk;
    tx_src.pos = st_r.s2.tx_pos;
    tx_src.neg = st_r.s2.tx_neg;
    if (st_r.mode == LBR_ANALOG) begin
      rec = st_r.line_q;
    end else begin
      rec.stb = st_r.s2.rx_clk && !st_r.s3.rx_clk;
      rec.pos = st_r.s2.rx_pos;
      rec.neg = st_r.s2.rx_neg;
    end

    // attenuator input: recovered data in remote, or when it sits in the receive path in none or analog
    ja_from_rec = (st_r.ctrl.ja_in_rx && (st_r.mode == LBR_NONE || st_r.mode == LBR_ANALOG ||
                   st_r.mode == LBR_REMOTE)) || st_r.mode == LBR_REMOTE;
    ja_in  = ja_from_rec ? rec : tx_src;
    ja_out = {st_r.ja_rd_q, ja_rdata};
    ja_stream = st_r.ctrl.ja_en ? ja_out : ja_in;

    // routing
    case (st_r.mode)
      LBR_REMOTE: begin
        line_src = ja_stream;
        rx_src   = (st_r.ctrl.ja_en && st_r.ctrl.ja_in_rx) ? ja_stream : rec;
      end
      LBR_DIGITAL: begin
        line_src = tx_src;
        rx_src   = ja_stream;
      end
      LBR_DUAL: begin
        line_src = rec;
        rx_src   = ja_stream;
      end
      default: begin
        line_src = (st_r.ctrl.ja_en && !st_r.ctrl.ja_in_rx) ? ja_stream : tx_src;
        rx_src   = (st_r.ctrl.ja_en && st_r.ctrl.ja_in_rx) ? ja_stream : rec;
      end
    endcase

    // attenuator: fixed-latency elastic store, half full before it pops
    ja_flush = !st_r.ctrl.ja_en || st_r.mode != st_nxt.mode;
    ja_wr    = st_r.ctrl.ja_en && ja_in.stb && !ja_flush;
    ja_rd    = ja_wr && st_r.ja_fill >= JA_FILL;
    ja_wdata = {ja_in.pos, ja_in.neg};
    st_nxt.ja_rd_q = ja_rd;
    if (ja_flush) begin
      st_nxt.ja_wp   = '0;
      st_nxt.ja_rp   = '0;
      st_nxt.ja_fill = '0;
    end else begin
      if (ja_wr) begin
        st_nxt.ja_wp = st_r.ja_wp + AW'(1);
      end
      if (ja_rd) begin
        st_nxt.ja_rp = st_r.ja_rp + AW'(1);
      end else if (ja_wr) begin
        st_nxt.ja_fill = st_r.ja_fill + (AW+1)'(1);
      end
    end

    // output stages
    st_nxt.line_q.stb = line_src.stb;
    if (line_src.stb) begin
      st_nxt.line_q.pos = line_src.pos;
      st_nxt.line_q.neg = line_src.neg;
    end
    st_nxt.rxo_q.stb = rx_src.stb;
    if (rx_src.stb) begin
      st_nxt.rxo_q.pos = rx_src.pos;
      st_nxt.rxo_q.neg = rx_src.neg;
    end
    st_nxt.line_cnt = half_cnt(line_src.stb, st_r.line_cnt);
    st_nxt.rxo_cnt  = half_cnt(rx_src.stb, st_r.rxo_cnt);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r.s1       <= lbr_sync_type'(LBR_SYNC_RST);
      st_r.s2       <= lbr_sync_type'(LBR_SYNC_RST);
      st_r.s3       <= lbr_sync_type'(LBR_SYNC_RST);
      st_r.ctrl     <= lbr_ctrl_type'(LBR_CTRL_RST);
      st_r.rdata    <= 32'h0000_0000;
      st_r.slverr   <= 1'b0;
      st_r.mode     <= LBR_NONE;
      st_r.auto_rl  <= 1'b0;
      st_r.ja_wp    <= '0;
      st_r.ja_rp    <= '0;
      st_r.ja_fill  <= '0;
      st_r.ja_rd_q  <= 1'b0;
      st_r.line_q   <= '0;
      st_r.rxo_q    <= '0;
      st_r.line_cnt <= '0;
      st_r.rxo_cnt  <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // attenuator storage

  lbr_ja_mem #(
    .WIDTH (2),
    .DEPTH (JA_DEPTH),
    .AW    (AW)
  ) u_ja_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (ja_wr),
    .wr_addr (st_r.ja_wp),
    .wr_data (ja_wdata),
    .rd_en   (ja_rd),
    .rd_addr (st_r.ja_rp),
    .rd_data (ja_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // zero-wait slave: read data was fetched in the setup cycle
  assign pready          = 1'b1;
  assign prdata          = st_r.rdata;
  assign pslverr         = st_r.slverr;
  assign tx_line_pos     = st_r.line_q.pos;
  assign tx_line_neg     = st_r.line_q.neg;
  // clock high once the half-bit count ran out; low while data settles
  assign tx_line_clk     = (st_r.line_cnt == '0);
  assign rx_data_pos_out = st_r.rxo_q.pos;
  assign rx_data_neg_out = st_r.rxo_q.neg;
  assign rx_clk_out      = (st_r.rxo_cnt == '0);

endmodule // lbr_router

// ===== test/lbr_link_model.sv
/*
  Bit source standing for the framer or the line: one clocked bipolar stream.
  Assumes pclk at 8 ns; a bit lasts 20 pclk, clock idles low between bits.
*/
`timescale 1ns/100ps

module lbr_link_model (
  input wire logic pclk,
  output     logic lclk,
  output     logic pos,
  output     logic neg
);
  // idles low like the router's reset synchronisers, so no false rise follows reset
  initial begin
    lclk = 1'b0;
    pos  = 1'b0;
    neg  = 1'b0;
  end

  // data moves only while the clock is low, then is spoiled once hold is over
  task automatic send(input logic [1:0] b);
    @(posedge pclk);
    lclk       <= 1'b0;
    {pos, neg} <= b;
    repeat (10) @(posedge pclk);
    lclk <= 1'b1;
    repeat (10) @(posedge pclk);
    lclk       <= 1'b0;
    {pos, neg} <= ~b;
  endtask
endmodule // lbr_link_model

// ===== test/lbr_router_sva.sv
/*
  Port checker for the loop-back router: APB answers and line/receive strobes.
  Assumes one pclk domain with presetn async active low; bound to every router.
*/
`timescale 1ns/100ps

module lbr_router_sva
  import lbr_pkg::*;
#(
  parameter int unsigned JA_DEPTH = LBR_JA_DEPTH_DEF,
  parameter int unsigned HALF_CYC = LBR_HALF_CYC
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        tx_line_pos,
  input wire logic        tx_line_neg,
  input wire logic        tx_line_clk,
  input wire logic        rx_data_pos_out,
  input wire logic        rx_data_neg_out,
  input wire logic        rx_clk_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic setup;
  logic bad;
  assign setup = psel && !penable;
  assign bad   = (paddr != LBR_CTRL_OFS) && (paddr != LBR_STAT_OFS);

  AST_PREADY: assert property (psel && penable |-> pready) else $error("pready low in access");
  AST_ERR: assert property (setup && bad |=> pslverr && prdata == 32'h0) else $error("unmapped not refused");
  AST_NOERR: assert property (setup && !bad |=> !pslverr) else $error("mapped access refused");
  AST_HIGH0: assert property (setup && !bad |=> prdata[31:7] == 25'h0) else $error("upper read bits set");
  // a shorter low phase would let the far end miss the bit
  AST_TXLOW: assert property ($fell(tx_line_clk) |-> !tx_line_clk [*8]) else $error("tx clock low short");
  AST_RXLOW: assert property ($fell(rx_clk_out) |-> !rx_clk_out [*8]) else $error("rx clock low short");
  AST_TXUPD: assert property ($changed({tx_line_pos, tx_line_neg}) |-> $fell(tx_line_clk))
    else $error("tx data moved off strobe");
  AST_RXUPD: assert property ($changed({rx_data_pos_out, rx_data_neg_out}) |-> $fell(rx_clk_out))
    else $error("rx data moved off strobe");

  cover property (setup && bad);
  cover property ($fell(tx_line_clk));
  cover property ($fell(rx_clk_out));
endmodule // lbr_router_sva

bind lbr_router lbr_router_sva #(.JA_DEPTH(JA_DEPTH), .HALF_CYC(HALF_CYC)) u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .tx_line_pos(tx_line_pos),
  .tx_line_neg(tx_line_neg), .tx_line_clk(tx_line_clk), .rx_data_pos_out(rx_data_pos_out),
  .rx_data_neg_out(rx_data_neg_out), .rx_clk_out(rx_clk_out)
);

// ===== test/lbr_router_tb.sv
/*
  Self-checking bench for the loop-back router: modes by pins and host bits.
  Assumes lbr_router with a 4-deep attenuator and the link model on both sides.
*/
`timescale 1ns/100ps

module lbr_router_tb
  import lbr_pkg::*;
;
  typedef struct packed {
    logic [6:0]   ctrl;
    logic [1:0]   pins;
    lbr_mode_type mode;
    logic         txl;
    logic         rxl;
  } lbr_case_type;

  // txl/rxl: line (1) or framer (0) feeds the line output / receive output
  localparam lbr_case_type CASES [15] = '{
    '{7'h00, 2'h0, LBR_NONE, 1'b0, 1'b1}, '{7'h00, 2'h1, LBR_ANALOG, 1'b0, 1'b0},
    '{7'h00, 2'h2, LBR_REMOTE, 1'b1, 1'b1}, '{7'h00, 2'h3, LBR_DIGITAL, 1'b0, 1'b0},
    '{7'h08, 2'h3, LBR_NONE, 1'b0, 1'b1}, '{7'h0C, 2'h0, LBR_DUAL, 1'b1, 1'b0},
    '{7'h0D, 2'h0, LBR_ANALOG, 1'b0, 1'b0}, '{7'h0E, 2'h0, LBR_REMOTE, 1'b1, 1'b1},
    '{7'h0F, 2'h0, LBR_DIGITAL, 1'b0, 1'b0}, '{7'h3D, 2'h0, LBR_ANALOG, 1'b0, 1'b0},
    '{7'h3E, 2'h0, LBR_REMOTE, 1'b1, 1'b1}, '{7'h1E, 2'h0, LBR_REMOTE, 1'b1, 1'b1},
    '{7'h1F, 2'h0, LBR_DIGITAL, 1'b0, 1'b0}, '{7'h1C, 2'h0, LBR_DUAL, 1'b1, 1'b0},
    '{7'h3C, 2'h0, LBR_DUAL, 1'b1, 1'b0}};

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mon_on;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic lb_pin_select_hi, lb_pin_select_lo, loop_up_req, loop_down_req;
  logic sys_tx_clk, sys_tx_pos, sys_tx_neg, rx_rec_clk, rx_line_pos, rx_line_neg;
  logic tx_line_pos, tx_line_neg, tx_line_clk, rx_data_pos_out, rx_data_neg_out, rx_clk_out;
  logic [32:0] qa[$];
  logic [1:0]  qt[$];
  logic [1:0]  qr[$];
  int failures, check_count;

  lbr_router #(.JA_DEPTH(4), .HALF_CYC(10)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .lb_pin_select_hi(lb_pin_select_hi), .lb_pin_select_lo(lb_pin_select_lo),
    .loop_up_req(loop_up_req), .loop_down_req(loop_down_req), .sys_tx_clk(sys_tx_clk),
    .sys_tx_pos(sys_tx_pos), .sys_tx_neg(sys_tx_neg), .rx_rec_clk(rx_rec_clk),
    .rx_line_pos(rx_line_pos), .rx_line_neg(rx_line_neg), .tx_line_pos(tx_line_pos),
    .tx_line_neg(tx_line_neg), .tx_line_clk(tx_line_clk), .rx_data_pos_out(rx_data_pos_out),
    .rx_data_neg_out(rx_data_neg_out), .rx_clk_out(rx_clk_out));
  lbr_link_model u_sys (.pclk(pclk), .lclk(sys_tx_clk), .pos(sys_tx_pos), .neg(sys_tx_neg));
  lbr_link_model u_line (.pclk(pclk), .lclk(rx_rec_clk), .pos(rx_line_pos), .neg(rx_line_neg));

  always #(LBR_CLK_NS / 2) pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // exp: {pslverr, prdata}; writes are judged on pslverr only
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] exp);
    int n;
    n = 0;
    @(posedge pclk);
    qa.push_back(exp);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16) begin
      @(posedge pclk);
      n++;
    end
    if (n == 16) begin
      failures++;
      finish_test();
    end else begin
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge pclk) begin
    if (psel && penable && pready && qa.size() > 0) begin
      if (pwrite) check("pslverr", 33'(pslverr), 33'(qa[0][32]));
      else check("read", {pslverr, prdata}, qa[0]);
      void'(qa.pop_front());
    end
    if (mon_on && $fell(tx_line_clk)) begin
      if (qt.size() == 0) check("tx extra", 33'h1, 33'h0);
      else check("tx_line", 33'({tx_line_pos, tx_line_neg}), 33'(qt.pop_front()));
    end
    if (mon_on && $fell(rx_clk_out)) begin
      if (qr.size() == 0) check("rx extra", 33'h1, 33'h0);
      else check("rx_out", 33'({rx_data_pos_out, rx_data_neg_out}), 33'(qr.pop_front()));
    end
  end

  initial begin
    repeat (60000) @(posedge pclk);
    failures++;
    finish_test();
  end

  initial begin
    lbr_case_type c;
    logic [1:0] bs, bl;
    int slack;
    {pclk, presetn, psel, penable, pwrite, mon_on} = 6'h00;
    {paddr, pwdata} = 40'h0;
    {lb_pin_select_hi, lb_pin_select_lo, loop_up_req, loop_down_req} = 4'h0;
    void'($urandom(70775));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, LBR_CTRL_OFS, 32'h0, 33'h0);
    apb(1'b0, LBR_STAT_OFS, 32'h0, 33'h0);
    apb(1'b1, LBR_STAT_OFS, 32'h3F, 33'h0);
    apb(1'b0, LBR_STAT_OFS, 32'h0, 33'h0);
    apb(1'b1, 8'h08, 32'h1, {1'b1, 32'h0});
    apb(1'b0, 8'h0C, 32'h0, {1'b1, 32'h0});
    apb(1'b1, LBR_CTRL_OFS, 32'hFFFFFFFF, 33'h0);
    apb(1'b0, LBR_CTRL_OFS, 32'h0, 33'h7F);
    $display("test registers done");
    // far-end loop-up under analog, then under none
    {lb_pin_select_hi, lb_pin_select_lo} <= 2'h1;
    loop_up_req <= 1'b1;
    apb(1'b1, LBR_CTRL_OFS, 32'h40, 33'h0);
    repeat (10) @(posedge pclk);
    apb(1'b0, LBR_STAT_OFS, 32'h0, 33'h11);
    {lb_pin_select_hi, lb_pin_select_lo} <= 2'h0;
    repeat (10) @(posedge pclk);
    apb(1'b0, LBR_STAT_OFS, 32'h0, 33'h1B);
    loop_up_req   <= 1'b0;
    loop_down_req <= 1'b1;
    repeat (10) @(posedge pclk);
    apb(1'b0, LBR_STAT_OFS, 32'h0, 33'h00);
    loop_down_req <= 1'b0;
    $display("test loop code done");
    for (int i = 0; i < 15; i++) begin
      c = CASES[i];
      // clearing ctrl first flushes the attenuator between cases
      apb(1'b1, LBR_CTRL_OFS, 32'h0, 33'h0);
      {lb_pin_select_hi, lb_pin_select_lo} <= c.pins;
      apb(1'b1, LBR_CTRL_OFS, {25'h0, c.ctrl}, 33'h0);
      repeat (8) @(posedge pclk);
      apb(0, LBR_STAT_OFS, 32'h0, {30'h0, c.mode});
      qt.delete();
      qr.delete();
      mon_on <= 1'b1;
      repeat (8) begin
        bs = 2'($urandom % 3);
        bl = 2'($urandom % 3);
        qt.push_back(c.txl ? bl : bs);
        qr.push_back(c.rxl ? bl : bs);
        fork
          u_sys.send(bs);
          u_line.send(bl);
        join
      end
      repeat (40) @(posedge pclk);
      mon_on <= 1'b0;
      // the attenuator keeps half its depth back
      slack = c.ctrl[4] ? 2 : 0;
      check("tx left", 33'(qt.size() <= slack), 33'h1);
      check("rx left", 33'(qr.size() <= slack), 33'h1);
      // an enabled attenuator has filled to half depth by now, mode unchanged
      apb(1'b0, LBR_STAT_OFS, 32'h0, {27'h0, c.ctrl[4], 2'h0, c.mode});
      $display("test mode %0d done", i);
    end
    finish_test();
  end
endmodule // lbr_router_tb
